// File: logic/frwp_pkg.sv
// Purpose: types for frwp
// Assumes: nothing
// Notes: states one-hot
package frwp_pkg;
	typedef enum logic [3:0] {
		FRWP_RECOV = 4'h1,
		FRWP_IDLE = 4'h2,
		FRWP_BUSY = 4'h4,
		FRWP_LATENCY = 4'h8
	} frwp_state_t;
endpackage

// File: logic/frwp_regs.svh
// Purpose: offsets, fields, reset values and timings in ns for frwp
// Assumes: 32-bit APB, 10 MHz pclk
// Notes: definitions only
`ifndef FRWP_REGS_SVH
`define FRWP_REGS_SVH
`define FRWP_CLK_NS 100
`define FRWP_REG_CTRL 12'h000
`define FRWP_REG_OP 12'h004
`define FRWP_REG_STATUS 12'h008
`define FRWP_REG_LOCK 12'h00C
`define FRWP_REG_IRQ_STAT 12'h010
`define FRWP_REG_IRQ_CLR 12'h014
`define FRWP_REG_IRQ_EN 12'h018
`define FRWP_LOCK_RST 8'h01
`define FRWP_CMD_UNI_ERASE 8'h20
`define FRWP_CMD_SEC_ERASE 8'h21
`define FRWP_CMD_PROG_A 8'h40
`define FRWP_CMD_PROG_B 8'h10
`define FRWP_ST_LOCKERR 0
`define FRWP_ST_BUSY 1
`define FRWP_ST_RECOV 2
`define FRWP_ST_ARRAY 3
`define FRWP_ST_ABORT 4
`define FRWP_IRQ_DONE 0
`define FRWP_IRQ_REFUSE 1
`define FRWP_IRQ_ABORT 2
`define FRWP_RECOV_BUS_NS 1000
`define FRWP_RECOV_MUX_NS 1000
`define FRWP_OP_NS 2000
`define FRWP_LATENCY_NS 500
`endif

// File: logic/frwp_top.sv
// Purpose: reset handling and hardware sector write protection
// Assumes: APB register access, pins synchronous to pclk
// Notes: operations started via OP register write
// Functional notes
// - reset low deselects, tristates, stops activity
// - leaving reset enters array-read mode
// - reset restores all lock registers write-locked
// - ignore commands during reset recovery interval
// - reset aborts program/erase, adds latency
// - top-boot pin low protects sector 10
// - hub mode: top-boot pin protects sectors 9-7
// - memory mode uniform erase: pin guards 10-7
// - memory mode: write-protect pin blocks program/sector erase 9-0
// - uniform erase: write-protect guards sectors 6-0
// - hub mode: write-protect guards sectors 6-0
// - pins sampled only at operation start
// - active pin overrides clear register lock
// - pins high, locks clear: accept operation
// - pins never alter lock register values
// - decode sectors from array address
// - lock refusal sets sector-lock error status
`timescale 1ns/100ps
`include "frwp_regs.svh"
module frwp_top #(
	parameter int RECOV_BUS_CYC =
		(`FRWP_RECOV_BUS_NS + `FRWP_CLK_NS - 1) / `FRWP_CLK_NS,
	parameter int RECOV_MUX_CYC =
		(`FRWP_RECOV_MUX_NS + `FRWP_CLK_NS - 1) / `FRWP_CLK_NS,
	parameter int OP_CYC = (`FRWP_OP_NS + `FRWP_CLK_NS - 1) / `FRWP_CLK_NS,
	parameter int LAT_CYC =
		(`FRWP_LATENCY_NS + `FRWP_CLK_NS - 1) / `FRWP_CLK_NS
) (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device reset inputs
	input wire logic dev_rst_n,
	input wire logic dev_init_n,
	// protect pins and mode
	input wire logic top_boot_lock_n,
	input wire logic wp_n,
	input wire logic hub_mode,
	input wire logic muxed_if,
	// array side and interrupt
	output logic mem_sel,
	output logic bus_oe,
	output logic array_write,
	output logic irq
);
	logic rst_act;
	assign rst_act = !dev_rst_n || !dev_init_n;

	frwp_pkg::frwp_state_t state_r;
	logic [15:0] cnt_r;
	logic [7:0] lock_r [0:10];
	logic array_mode_r, lockerr_r, abort_r;
	logic [7:0] op_cmd_r;
	logic [18:0] op_addr_r;
	logic [2:0] irq_stat_r, irq_en_r;
	logic was_busy_r;
	// pin levels of the running op, read back through OP
	logic [1:0] op_pins_r;

	// sector index from array address
	function automatic logic [3:0] sector_of(input logic [18:0] a);
		if (a[18:16] != 3'h7)
			sector_of = {1'b0, a[18:16]};
		else if (a[15])
			sector_of = 4'hA;
		else if (a[14:13] == 2'h3)
			sector_of = 4'h9;
		else if (a[14:13] == 2'h2)
			sector_of = 4'h8;
		else
			sector_of = 4'h7;
	endfunction

	// hardware pin verdict, from live pin levels in the accepting cycle
	function automatic logic pin_block(input logic [3:0] s,
		input logic [7:0] cmd, input logic hub, input logic tbl_n,
		input logic wpn);
		logic top;
		top = (s >= 4'h7);
		if (s == 4'hA)
			pin_block = !tbl_n;
		else if (hub)
			pin_block = top ? !tbl_n : !wpn;
		else if (cmd == `FRWP_CMD_UNI_ERASE)
			pin_block = top ? !tbl_n : !wpn;
		else
			pin_block = !wpn;
	endfunction

	// hub mode shares one lock register for the top sectors
	function automatic logic [3:0] lock_idx(input logic [3:0] s,
		input logic hub);
		lock_idx = (hub && s >= 4'h7) ? 4'hA : s;
	endfunction

	// recovery length depends on which interface saw the reset
	function automatic logic [15:0] recov_len(input logic mux);
		if (mux)
			recov_len = 16'(RECOV_MUX_CYC);
		else
			recov_len = 16'(RECOV_BUS_CYC);
	endfunction

	// only the four program and erase opcodes start anything
	function automatic logic known_cmd(input logic [7:0] c);
		known_cmd = c == `FRWP_CMD_UNI_ERASE ||
			c == `FRWP_CMD_SEC_ERASE ||
			c == `FRWP_CMD_PROG_A ||
			c == `FRWP_CMD_PROG_B;
	endfunction

	// register map membership; other offsets answer with an error
	function automatic logic mapped(input logic [11:0] a);
		case (a)
			`FRWP_REG_CTRL,
			`FRWP_REG_OP,
			`FRWP_REG_STATUS,
			`FRWP_REG_LOCK,
			`FRWP_REG_IRQ_STAT,
			`FRWP_REG_IRQ_CLR,
			`FRWP_REG_IRQ_EN:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
		endcase
	endfunction

	// status word: abort, array, recovering, busy, lock error
	function automatic logic [31:0] status_word(
		input frwp_pkg::frwp_state_t s, input logic arr,
		input logic lerr, input logic abt);
		logic recov, busy;
		recov = s == frwp_pkg::FRWP_RECOV ||
			s == frwp_pkg::FRWP_LATENCY;
		busy = s == frwp_pkg::FRWP_BUSY;
		status_word = {27'h0000000, abt, arr, recov, busy, lerr};
	endfunction

	logic is_cmd;
	assign is_cmd = known_cmd(op_cmd_r);

	logic wr, rd, op_wr;
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;

	// per-register write strobes, access phase only
	logic ctrl_wr, lock_wr, irq_clr_wr, irq_en_wr;
	assign ctrl_wr = wr && paddr == `FRWP_REG_CTRL;
	assign lock_wr = wr && paddr == `FRWP_REG_LOCK;
	assign irq_clr_wr = wr && paddr == `FRWP_REG_IRQ_CLR;
	assign irq_en_wr = wr && paddr == `FRWP_REG_IRQ_EN;
	logic [18:0] addr_in;
	logic [7:0] cmd_in;
	assign addr_in = pwdata[18:0];
	assign cmd_in = pwdata[31:24];
	assign op_wr = wr && paddr == `FRWP_REG_OP;

	// verdict computed with pin levels of the accepting cycle
	logic [3:0] sec_in;
	logic refuse;
	logic uni_top;
	logic pin_ref, reg_ref, top_ref;
	assign sec_in = sector_of(addr_in);
	assign uni_top = !hub_mode && cmd_in == `FRWP_CMD_UNI_ERASE &&
		sec_in >= 4'h7;
	// a low pin refuses whatever the register says
	assign pin_ref = pin_block(sec_in, cmd_in, hub_mode,
		top_boot_lock_n, wp_n);
	// a high pin still leaves the register lock in force
	assign reg_ref = lock_r[lock_idx(sec_in, hub_mode)][0];
	// memory-mode uniform erase of the top spans four registers
	assign top_ref = uni_top && (lock_r[7][0] || lock_r[8][0] ||
		lock_r[9][0] || lock_r[10][0]);
	assign refuse = pin_ref || reg_ref || top_ref;

	// op writes outside idle are dropped without any report
	logic accept;
	assign accept = op_wr && state_r == frwp_pkg::FRWP_IDLE &&
		known_cmd(cmd_in);

	// control state machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= frwp_pkg::FRWP_RECOV;
			cnt_r <= 16'h0000;
		end else if (rst_act) begin
			// abort in flight keeps latency; else just hold
			if (state_r == frwp_pkg::FRWP_BUSY ||
				state_r == frwp_pkg::FRWP_LATENCY) begin
				state_r <= frwp_pkg::FRWP_LATENCY;
				cnt_r <= 16'(LAT_CYC);
			end else begin
				state_r <= frwp_pkg::FRWP_RECOV;
				// reloaded while held, so timing starts at release
				cnt_r <= recov_len(muxed_if);
			end
		end else begin
			unique case (state_r)
				frwp_pkg::FRWP_RECOV: begin
					if (cnt_r == 16'h0000)
						state_r <= frwp_pkg::FRWP_IDLE;
					else
						cnt_r <= cnt_r - 16'h0001;
				end
				frwp_pkg::FRWP_IDLE: begin
					if (accept && !refuse) begin
						state_r <= frwp_pkg::FRWP_BUSY;
						cnt_r <= 16'(OP_CYC);
					end
				end
				frwp_pkg::FRWP_BUSY: begin
					if (cnt_r == 16'h0000)
						state_r <= frwp_pkg::FRWP_IDLE;
					else
						cnt_r <= cnt_r - 16'h0001;
				end
				frwp_pkg::FRWP_LATENCY: begin
					// latency then normal recovery
					if (cnt_r == 16'h0000) begin
						state_r <= frwp_pkg::FRWP_RECOV;
						cnt_r <= recov_len(muxed_if);
					end else
						cnt_r <= cnt_r - 16'h0001;
				end
			endcase
		end
	end

	// captured operation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_cmd_r <= 8'h00;
			op_addr_r <= 19'h00000;
			op_pins_r <= 2'h0;
		end else if (accept) begin
			op_cmd_r <= cmd_in;
			op_addr_r <= addr_in;
			op_pins_r <= {top_boot_lock_n, wp_n};
		end
	end

	// lock registers; pins never touch them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 11; i++)
				lock_r[i] <= `FRWP_LOCK_RST;
		end else if (rst_act) begin
			for (int i = 0; i < 11; i++)
				lock_r[i] <= `FRWP_LOCK_RST;
		end else if (lock_wr &&
			pwdata[11:8] <= 4'hA && state_r == frwp_pkg::FRWP_IDLE) begin
			// lock-down freezes the register until reset
			if (!lock_r[pwdata[11:8]][1])
				lock_r[pwdata[11:8]] <= {5'h00, pwdata[2:0]};
		end
	end

	// array-read mode and status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			array_mode_r <= 1'b1;
			lockerr_r <= 1'b0;
			abort_r <= 1'b0;
		end else if (rst_act) begin
			array_mode_r <= 1'b1;
			lockerr_r <= 1'b0;
			abort_r <= abort_r || state_r == frwp_pkg::FRWP_BUSY;
		end else begin
			if (accept)
				array_mode_r <= 1'b0;
			else if (ctrl_wr && pwdata[0])
				array_mode_r <= 1'b1;
			if (accept && refuse)
				lockerr_r <= 1'b1;
			else if (ctrl_wr && pwdata[1])
				lockerr_r <= 1'b0;
			if (ctrl_wr && pwdata[2])
				abort_r <= 1'b0;
		end
	end

	// interrupts: set wins over clear
	logic [2:0] ev;
	always_comb begin
		ev = 3'h0;
		ev[`FRWP_IRQ_DONE] = was_busy_r && state_r == frwp_pkg::FRWP_IDLE;
		ev[`FRWP_IRQ_REFUSE] = accept && refuse;
		ev[`FRWP_IRQ_ABORT] = rst_act && state_r == frwp_pkg::FRWP_BUSY;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= 3'h0;
			irq_en_r <= 3'h0;
			was_busy_r <= 1'b0;
			irq <= 1'b0;
		end else begin
			was_busy_r <= state_r == frwp_pkg::FRWP_BUSY;
			if (irq_en_wr)
				irq_en_r <= pwdata[2:0];
			// an event in the clearing cycle survives the clear
			irq_stat_r <= (irq_stat_r &
				~(irq_clr_wr ? pwdata[2:0] : 3'h0)) | ev;
			irq <= |(irq_stat_r & irq_en_r);
		end
	end

	// array and pin side outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_sel <= 1'b0;
			bus_oe <= 1'b0;
			array_write <= 1'b0;
		end else begin
			mem_sel <= !rst_act && state_r != frwp_pkg::FRWP_LATENCY;
			bus_oe <= !rst_act && array_mode_r;
			array_write <= !rst_act && state_r == frwp_pkg::FRWP_BUSY &&
				is_cmd;
		end
	end

	// apb: zero wait states, reads registered in setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			// error rides on the ready pulse, never on its own
			pslverr <= psel && !penable && !mapped(paddr);
			if (rd) begin
				unique case (paddr)
					`FRWP_REG_OP:
						prdata <= {op_cmd_r, 3'h0, op_pins_r,
							op_addr_r};
					`FRWP_REG_STATUS:
						prdata <= status_word(state_r, array_mode_r,
							lockerr_r, abort_r);
					`FRWP_REG_IRQ_STAT:
						prdata <= {29'h00000000, irq_stat_r};
					`FRWP_REG_IRQ_EN:
						prdata <= {29'h00000000, irq_en_r};
					`FRWP_REG_LOCK:
						prdata <= (pwdata[11:8] <= 4'hA) ?
							{24'h000000, lock_r[pwdata[11:8]]} :
							32'h00000000;
					default:
						prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

// File: tb/frwp_host.sv
// Purpose: host side model driving resets and protect pins
// Assumes: changes only just after a rising edge
// Notes: tasks called from tb
`timescale 1ns/100ps
module frwp_host #(
	parameter int RST_MIN_CYC = 3
) (
	// clock
	input wire logic pclk,
	// resets, pins, mode
	output logic dev_rst_n,
	output logic dev_init_n,
	output logic top_boot_lock_n,
	output logic wp_n,
	output logic hub_mode,
	output logic muxed_if
);
	initial begin
		dev_rst_n = 1'b1;
		dev_init_n = 1'b1;
		top_boot_lock_n = 1'b1;
		wp_n = 1'b1;
		hub_mode = 1'b0;
		muxed_if = 1'b0;
	end
	// pins settle well before the op request
	task pins(input logic h, input logic t, input logic w);
		@(posedge pclk);
		hub_mode <= h;
		top_boot_lock_n <= t;
		wp_n <= w;
	endtask
	task pulse(input logic use_init);
		@(posedge pclk);
		muxed_if <= use_init;
		if (use_init) begin
			dev_init_n <= 1'b0;
		end else begin
			dev_rst_n <= 1'b0;
		end
		repeat (RST_MIN_CYC) @(posedge pclk);
		dev_init_n <= 1'b1;
		dev_rst_n <= 1'b1;
	endtask
endmodule

// File: tb/frwp_props.sv
// Purpose: concurrent checks on frwp_top ports
// Assumes: one clock domain, presetn active low
// Notes: bound to frwp_top below
`timescale 1ns/100ps
module frwp_props (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// device side
	input wire logic dev_rst_n,
	input wire logic dev_init_n,
	input wire logic mem_sel,
	input wire logic bus_oe,
	input wire logic array_write
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence release_s;
		$rose(dev_rst_n && dev_init_n);
	endsequence
	sequence setup_s;
		psel && !penable;
	endsequence
	AST_RST_QUIET: assert property (!dev_rst_n |=> !mem_sel && !bus_oe)
		else $error("drivers active while reset low");
	AST_INIT_QUIET: assert property (!dev_init_n |=> !mem_sel && !bus_oe)
		else $error("drivers active while init low");
	AST_ABORT: assert property (
		array_write && !(dev_rst_n && dev_init_n) |=> !array_write)
		else $error("operation not aborted by reset");
	AST_RECOV: assert property (release_s |-> !array_write [*8])
		else $error("operation started during recovery");
	AST_ARRAY: assert property (release_s |-> ##[1:2] bus_oe)
		else $error("array read mode not entered");
	AST_READY: assert property (setup_s |=> pready)
		else $error("no ready in access phase");
	AST_READY_PH: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	AST_ERR: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule
bind frwp_top frwp_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.dev_rst_n(dev_rst_n), .dev_init_n(dev_init_n), .mem_sel(mem_sel),
	.bus_oe(bus_oe), .array_write(array_write));

// File: tb/tb.sv
// Purpose: register level test of frwp_top
// Assumes: zero wait APB, default counts
// Notes: protect cases held in a table
`timescale 1ns/100ps
`include "frwp_regs.svh"
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic dev_rst_n, dev_init_n, tbl_n, wp_n, hub_mode, muxed_if;
	logic mem_sel, bus_oe, array_write, e;
	int err_count, cmp_count;
	// {cmd, hub, tbl_n, wp_n, refused, addr}
	localparam logic [31:0] TC [10] = '{32'h40378000, 32'h40276000,
		32'h10576000, 32'h20370000, 32'h20470000, 32'h2056FFFF,
		32'h10B74000, 32'h21D6FFFF, 32'h21A6FFFF, 32'h21678000};
	frwp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dev_rst_n(dev_rst_n), .dev_init_n(dev_init_n),
		.top_boot_lock_n(tbl_n), .wp_n(wp_n), .hub_mode(hub_mode),
		.muxed_if(muxed_if), .mem_sel(mem_sel), .bus_oe(bus_oe),
		.array_write(array_write), .irq(irq));
	frwp_host host (.pclk(pclk), .dev_rst_n(dev_rst_n),
		.dev_init_n(dev_init_n), .top_boot_lock_n(tbl_n), .wp_n(wp_n),
		.hub_mode(hub_mode), .muxed_if(muxed_if));
	task final_report;
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			err_count++;
			final_report();
		end
	endtask
	task wait_idle;
		int n;
		n = 0;
		q = 32'h2;
		while (q[1] !== 1'b0 && n < 50) begin
			apb(1'b0, `FRWP_REG_STATUS, 32'h0);
			n++;
		end
		if (n >= 50) begin
			err_count++;
			final_report();
		end
	endtask
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		err_count = 0;
		cmp_count = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (12) @(posedge pclk);
		apb(1'b0, `FRWP_REG_STATUS, 32'h0);
		chk(q[3], 1'b1);
		for (int i = 0; i <= 10; i++) begin
			apb(1'b0, `FRWP_REG_LOCK, i << 8);
			chk(q, `FRWP_LOCK_RST);
			apb(1'b1, `FRWP_REG_LOCK, i << 8);
		end
		apb(1'b0, 12'h01C, 32'h0);
		chk({31'h00000000, e}, 32'h00000001);
		chk(q, 32'h00000000);
		apb(1'b1, `FRWP_REG_IRQ_EN, 32'h2);
		for (int i = 0; i < 10; i++) begin
			host.pins(TC[i][23], TC[i][22], TC[i][21]);
			apb(1'b1, `FRWP_REG_OP, TC[i] & 32'hFF07FFFF);
			apb(1'b0, `FRWP_REG_STATUS, 32'h0);
			chk({q[0], array_write, irq}, {TC[i][20], !TC[i][20],
				TC[i][20] || i != 0});
			wait_idle();
			apb(1'b1, `FRWP_REG_CTRL, 32'h2);
		end
		apb(1'b0, `FRWP_REG_LOCK, 32'hA00);
		chk(q, 32'h0);
		apb(1'b1, `FRWP_REG_IRQ_EN, 32'h0);
		apb(1'b0, `FRWP_REG_IRQ_STAT, 32'h0);
		chk({q[2:0], irq}, 4'h6);
		apb(1'b1, `FRWP_REG_IRQ_CLR, 32'h7);
		apb(1'b0, `FRWP_REG_IRQ_STAT, 32'h0);
		chk(q, 32'h0);
		host.pins(1'b0, 1'b1, 1'b1);
		apb(1'b1, `FRWP_REG_OP, 32'h40076000);
		host.pulse(1'b0);
		apb(1'b1, `FRWP_REG_OP, 32'h40076000);
		apb(1'b0, `FRWP_REG_STATUS, 32'h0);
		chk({q[4], q[0], array_write}, 3'b100);
		apb(1'b0, `FRWP_REG_LOCK, 32'h900);
		chk(q, `FRWP_LOCK_RST);
		host.pulse(1'b1);
		repeat (30) @(posedge pclk);
		apb(1'b0, `FRWP_REG_LOCK, 32'h900);
		chk(q, `FRWP_LOCK_RST);
		apb(1'b0, `FRWP_REG_STATUS, 32'h0);
		chk({q[3], bus_oe, mem_sel}, 3'b111);
		final_report();
	end
endmodule
